// *** rtl/sma_params.svh ***
`ifndef SMA_PARAMS_SVH
`define SMA_PARAMS_SVH

`define SMA_CLK_MHZ        200
`define SMA_RESTORE_MIN_NS 450
`define SMA_STORE_MIN_NS   100
`define SMA_STORE_MS       10
`define SMA_RESTORE_CYC    ((`SMA_RESTORE_MIN_NS * `SMA_CLK_MHZ + 999) / 1000)
`define SMA_STORE_CYC      ((`SMA_STORE_MIN_NS * `SMA_CLK_MHZ + 999) / 1000)
`define SMA_STORE_WAIT_CYC (`SMA_STORE_MS * `SMA_CLK_MHZ * 1000)

`define SMA_MEM_CYC        2
`define SMA_AUX_PRIV_TOP   16'h0800
`define SMA_STD_HI         3'h0
`define SMA_NVM_HI         7'h76
`define SMA_ROM_HI         4'hf
`define SMA_SYNC_RST       30'h0000003f

`endif

// *** rtl/sma_pkg.sv ***
package sma_pkg;
    typedef enum logic [2:0] {
        SMA_IDLE    = 3'h0,
        SMA_REFRESH = 3'h1,
        SMA_DMA     = 3'h3,
        SMA_MAIN    = 3'h2,
        SMA_AUX     = 3'h6
    } sma_owner_t;
endpackage

// *** rtl/sma_nvm.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sma_params.svh"

module sma_nvm #(
    parameter int STORE_WAIT_CYC = `SMA_STORE_WAIT_CYC
) (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       restore_bit_n,
    input  wire logic       store_bit,
    input  wire logic       wr,
    input  wire logic [7:0] addr,
    input  wire logic [3:0] wdata,
    output logic      [3:0] rdata,
    output logic            busy
);
    import sma_pkg::*;

    localparam int RCYC = `SMA_RESTORE_CYC;
    localparam int SCYC = `SMA_STORE_CYC;

    logic [3:0]  shadow_q [256];
    logic [3:0]  cells_q  [256];
    logic [7:0]  rlow_q;
    logic [7:0]  shigh_q;
    logic [31:0] timer_q;
    logic        rbit_q;
    logic        sbit_q;
    logic        do_restore;
    logic        do_store;

    assign busy = (timer_q != 32'h0);
    // short pulses are ignored; a store in flight blocks everything
    assign do_restore = restore_bit_n & ~rbit_q & (rlow_q >= 8'(RCYC))
                        & ~busy;
    assign do_store = ~store_bit & sbit_q & (shigh_q >= 8'(SCYC))
                      & ~busy;
    assign rdata = busy ? 4'h0 : shadow_q[addr];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rbit_q <= 1'b1;
            sbit_q <= 1'b0;
            rlow_q <= 8'h0;
            shigh_q <= 8'h0;
        end else begin
            rbit_q <= restore_bit_n;
            sbit_q <= store_bit;
            if (restore_bit_n) begin
                rlow_q <= 8'h0;
            end else if (rlow_q != 8'hff) begin
                rlow_q <= rlow_q + 8'h1;
            end
            if (!store_bit) begin
                shigh_q <= 8'h0;
            end else if (shigh_q != 8'hff) begin
                shigh_q <= shigh_q + 8'h1;
            end
        end
    end

    // once started the store runs to the end; only arst_n can abort it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            timer_q <= 32'h0;
        end else if (do_store) begin
            timer_q <= 32'(STORE_WAIT_CYC);
        end else if (busy) begin
            timer_q <= timer_q - 32'h1;
        end
    end

    for (genvar i = 0; i < 256; i++) begin : g_cell
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                shadow_q[i] <= 4'h0;
                cells_q[i] <= 4'h0;
            end else begin
                if (do_restore) begin
                    shadow_q[i] <= cells_q[i];
                end else if (wr && !busy && addr == 8'(i)) begin
                    shadow_q[i] <= wdata;
                end
                if (do_store) begin
                    cells_q[i] <= shadow_q[i];
                end
            end
        end
    end
endmodule

`default_nettype wire

// *** rtl/sma_arbiter.sv ***
// Function
// - fetch with memory request is opcode fetch; with port request, acknowledge.
// - refresh with memory request: low 7 address bits are a refresh row.
// - aux wait held low while addressed memory not ready; aux keeps waiting.
// - on aux read strobe the addressed memory drives the aux data bus.
// - aux reaches only 62K of low bank; first 2K unreachable to it.
// - main access to high bank waits while aux uses the low bank.
// - main standard access needs no wait when idle, stalls behind running cycles.
// - priority: refresh first, DMA second, processors last and about equal.
// - standard memory has no parity generation or checking.
// - ROM needs no wait states except while refresh is in progress.
// - private expansion memory has no wait states except during refresh.
// - nonvolatile memory decodes 256 locations, data bits 0-3, phantom images.
// - after restore, accesses act on the 256x4 static shadow.
// - store bit high at least 100 ns then low; memory off 10 ms.
// - nonvolatile operations during the store interval are ignored.
// - aux shared access waits while main or refresh cycle runs or pends; a pending aux access goes ahead of a pending main one when turn_q is set.
// - aux opcode fetch from shared memory gets one extra wait state.
// - aux private 2K memory is always reached without wait states.
`timescale 1ns/1ps
`default_nettype none
`include "sma_params.svh"

module sma_arbiter #(
    parameter int MEM_CYC        = `SMA_MEM_CYC,
    parameter int STORE_WAIT_CYC = `SMA_STORE_WAIT_CYC
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [15:0] aux_address_bus,
    input  wire logic [7:0]  aux_data_bus_in,
    output logic      [7:0]  aux_data_bus_out,
    output logic             aux_data_bus_oe,
    input  wire logic        aux_mem_request_n,
    input  wire logic        aux_port_request_n,
    input  wire logic        aux_opcode_fetch_n,
    input  wire logic        aux_refresh_n,
    input  wire logic        aux_read_n,
    input  wire logic        aux_write_n,
    output logic             aux_wait_n,
    output logic      [6:0]  aux_refresh_row,
    input  wire logic        mp_req,
    input  wire logic [19:0] mp_addr,
    input  wire logic        mp_we,
    input  wire logic [7:0]  mp_wdata,
    output logic      [7:0]  mp_rdata,
    output logic             mp_ready,
    input  wire logic [7:0]  ext_rdata,
    input  wire logic        ref_req,
    output logic             ref_ack,
    input  wire logic        dma_req,
    input  wire logic [16:0] dma_addr,
    input  wire logic        dma_we,
    input  wire logic [7:0]  dma_wdata,
    output logic             dma_ack,
    output logic             mem_sel,
    output logic             mem_refresh,
    output logic             mem_we,
    output logic      [16:0] mem_addr,
    output logic      [7:0]  mem_wdata,
    input  wire logic [7:0]  mem_rdata,
    input  wire logic        nvm_restore_bit_n,
    input  wire logic        nvm_store_bit
);
    import sma_pkg::*;

    logic [29:0] s1_q;
    logic [29:0] s2_q;
    logic [29:0] s3_q;
    logic [29:0] f_q;
    logic [29:0] raw;
    logic [15:0] a_addr;
    logic [7:0]  a_din;
    logic        a_mreq;
    logic        a_m1;
    logic        a_rfsh;
    logic        a_rd;
    logic        a_wr;
    logic        a_mem;
    logic        a_priv;
    logic        a_shared;
    logic [7:0]  priv_q [2048];
    logic        aux_served_q;
    logic        aux_extra_q;
    logic        aux_want;
    sma_owner_t  owner_q;
    logic [7:0]  cnt_q;
    logic        turn_q;
    logic        done;
    logic        mp_served_q;
    logic        mp_std;
    logic        mp_nvm;
    logic        mp_local;
    logic        mp_want;
    logic [3:0]  nvm_rdata;
    logic        nvm_busy;

    // pins arrive asynchronously to clk
    assign raw = {aux_address_bus, aux_data_bus_in, aux_mem_request_n,
                  aux_port_request_n, aux_opcode_fetch_n, aux_refresh_n,
                  aux_read_n, aux_write_n};

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= `SMA_SYNC_RST;
            s2_q <= `SMA_SYNC_RST;
            s3_q <= `SMA_SYNC_RST;
            f_q <= `SMA_SYNC_RST;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                f_q <= s3_q;
            end
        end
    end

    // port cycles and acknowledge need nothing from this block
    assign a_addr = f_q[29:14];
    assign a_din = f_q[13:6];
    assign a_mreq = ~f_q[5];
    assign a_m1 = ~f_q[3];
    assign a_rfsh = ~f_q[2];
    assign a_rd = ~f_q[1];
    assign a_wr = ~f_q[0];
    assign a_mem = a_mreq & ~a_rfsh & (a_rd | a_wr);
    // the bottom 2K of the aux map hits private RAM, so the low bank
    // vectors stay out of its reach
    assign a_priv = a_mem & (a_addr < `SMA_AUX_PRIV_TOP);
    assign a_shared = a_mem & ~a_priv;
    assign aux_want = a_shared & ~aux_served_q & ~aux_extra_q;

    assign mp_std = (mp_addr[19:17] == `SMA_STD_HI);
    assign mp_nvm = (mp_addr[19:13] == `SMA_NVM_HI);
    assign mp_local = ~mp_std & ~mp_nvm;
    assign mp_want = mp_req & mp_std & ~mp_served_q;
    assign done = (owner_q != SMA_IDLE) && (cnt_q == 8'(MEM_CYC - 1));

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aux_refresh_row <= 7'h0;
        end else if (a_mreq && a_rfsh) begin
            aux_refresh_row <= a_addr[6:0];
        end
    end

    // no parity bits stored or checked anywhere on this bus
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            owner_q <= SMA_IDLE;
            cnt_q <= 8'h0;
            turn_q <= 1'b0;
            mem_sel <= 1'b0;
            mem_refresh <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= 17'h0;
            mem_wdata <= 8'h0;
        end else if (owner_q != SMA_IDLE) begin
            // a running cycle is never preempted
            cnt_q <= cnt_q + 8'h1;
            if (done) begin
                owner_q <= SMA_IDLE;
                cnt_q <= 8'h0;
                mem_sel <= 1'b0;
                mem_refresh <= 1'b0;
                mem_we <= 1'b0;
            end
        end else if (ref_req && !ref_ack) begin
            owner_q <= SMA_REFRESH;
            mem_sel <= 1'b1;
            mem_refresh <= 1'b1;
        end else if (dma_req && !dma_ack) begin
            owner_q <= SMA_DMA;
            mem_sel <= 1'b1;
            mem_we <= dma_we;
            mem_addr <= dma_addr;
            mem_wdata <= dma_wdata;
        end else if (mp_want && (!aux_want || !turn_q)) begin
            owner_q <= SMA_MAIN;
            turn_q <= 1'b1;
            mem_sel <= 1'b1;
            mem_we <= mp_we;
            mem_addr <= mp_addr[16:0];
            mem_wdata <= mp_wdata;
        end else if (aux_want) begin
            owner_q <= SMA_AUX;
            turn_q <= 1'b0;
            mem_sel <= 1'b1;
            mem_we <= a_wr;
            mem_addr <= {1'b0, a_addr};
            mem_wdata <= a_din;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ref_ack <= 1'b0;
            dma_ack <= 1'b0;
        end else begin
            ref_ack <= done && owner_q == SMA_REFRESH;
            dma_ack <= done && owner_q == SMA_DMA;
        end
    end

    // aux side: wait until its shared cycle is served, plus one for a fetch
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aux_served_q <= 1'b0;
            aux_extra_q <= 1'b0;
            aux_wait_n <= 1'b1;
        end else begin
            aux_extra_q <= done && owner_q == SMA_AUX && a_m1;
            if (done && owner_q == SMA_AUX) begin
                aux_served_q <= 1'b1;
            end else if (!a_shared) begin
                aux_served_q <= 1'b0;
            end
            aux_wait_n <= ~(aux_want | (owner_q == SMA_AUX)
                            | aux_extra_q);
        end
    end

    for (genvar i = 0; i < 2048; i++) begin : g_priv
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                priv_q[i] <= 8'h0;
            end else if (a_priv && a_wr && a_addr[10:0] == 11'(i)) begin
                priv_q[i] <= a_din;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aux_data_bus_out <= 8'h0;
            aux_data_bus_oe <= 1'b0;
        end else begin
            aux_data_bus_oe <= a_mem & a_rd;
            if (a_priv && a_rd) begin
                aux_data_bus_out <= priv_q[a_addr[10:0]];
            end else if (done && owner_q == SMA_AUX) begin
                aux_data_bus_out <= mem_rdata;
            end
        end
    end

    // main side; local memories only stall behind a refresh cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mp_served_q <= 1'b0;
            mp_ready <= 1'b0;
            mp_rdata <= 8'h0;
        end else begin
            mp_ready <= 1'b0;
            if (!mp_req) begin
                mp_served_q <= 1'b0;
            end else if (done && owner_q == SMA_MAIN) begin
                mp_served_q <= 1'b1;
                mp_ready <= 1'b1;
                mp_rdata <= mem_rdata;
            end else if (!mp_served_q && mp_nvm) begin
                mp_served_q <= 1'b1;
                mp_ready <= 1'b1;
                mp_rdata <= {4'h0, nvm_rdata};
            end else if (!mp_served_q && mp_local
                         && owner_q != SMA_REFRESH) begin
                mp_served_q <= 1'b1;
                mp_ready <= 1'b1;
                mp_rdata <= ext_rdata;
            end
        end
    end

    sma_nvm #(
        .STORE_WAIT_CYC (STORE_WAIT_CYC)
    ) u_nvm (
        .clk           (clk),
        .arst_n        (arst_n),
        .restore_bit_n (nvm_restore_bit_n),
        .store_bit     (nvm_store_bit),
        .wr            (mp_req & mp_nvm & mp_we & ~mp_served_q),
        .addr          (mp_addr[7:0]),
        .wdata         (mp_wdata[3:0]),
        .rdata         (nvm_rdata),
        .busy          (nvm_busy)
    );
endmodule

`default_nettype wire

// *** dv/sma_arbiter_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module sma_arbiter_monitor #(
    parameter int MEM_CYC = 2
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [15:0] aux_address_bus,
    input  wire logic        aux_mem_request_n,
    input  wire logic        aux_refresh_n,
    input  wire logic        aux_read_n,
    input  wire logic        aux_data_bus_oe,
    input  wire logic        aux_wait_n,
    input  wire logic        mp_req,
    input  wire logic [19:0] mp_addr,
    input  wire logic        mp_we,
    input  wire logic [7:0]  mp_rdata,
    input  wire logic        mp_ready,
    input  wire logic        ref_req,
    input  wire logic        ref_ack,
    input  wire logic        dma_req,
    input  wire logic        dma_ack,
    input  wire logic        mem_sel,
    input  wire logic        mem_refresh,
    input  wire logic [7:0]  mem_rdata
);
    localparam int READY_DLY = MEM_CYC + 1;
    logic [7:0] rd_seen_q;
    // history long enough to cover the pin synchroniser delay
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_seen_q <= 8'h00;
        end else begin
            rd_seen_q <= {rd_seen_q[6:0], !aux_read_n && !aux_mem_request_n};
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    chk_main_idle_fast: assert property (
        $rose(mp_req) && mp_addr[19:17] == 3'h0 && !mem_sel && !ref_req
        && !dma_req && aux_mem_request_n |-> ##READY_DLY mp_ready)
        else $error("idle main access not answered on time");
    chk_refresh_wins: assert property (
        $rose(mem_sel) && $past(ref_req) && !$past(ref_req, 2) |-> mem_refresh)
        else $error("new refresh request lost the bus");
    chk_refresh_ack_time: assert property (
        $rose(mem_sel) && mem_refresh |-> ##MEM_CYC ref_ack)
        else $error("refresh ack late");
    chk_dma_over_cpu: assert property (
        $rose(mem_sel) && $past(dma_req) && !$past(dma_req, 2)
        && !$past(ref_req) |-> ##MEM_CYC dma_ack)
        else $error("new dma request lost the bus to a processor");
    chk_local_fast: assert property (
        $rose(mp_req) && mp_addr[19:17] != 3'h0 && !ref_req && !mem_refresh
        |=> mp_ready)
        else $error("local access waited without refresh");
    chk_nvm_nibble: assert property (
        mp_ready && mp_addr[19:13] == 7'h76 |-> mp_rdata[7:4] == 4'h0)
        else $error("nonvolatile read drove upper bits");
    chk_std_read_data: assert property (
        mp_ready && !mp_we && mp_addr[19:17] == 3'h0
        |-> mp_rdata == $past(mem_rdata))
        else $error("standard read data altered");
    chk_oe_on_read: assert property (
        aux_data_bus_oe |-> rd_seen_q != 8'h00)
        else $error("aux data bus driven without a read");
    chk_aux_wait_bound: assert property (
        $fell(aux_wait_n) |-> ##[1:120] aux_wait_n)
        else $error("aux wait held too long");
    chk_private_nowait: assert property (
        (!aux_mem_request_n && aux_refresh_n
         && aux_address_bus < 16'h0800)[*8] |-> aux_wait_n)
        else $error("private aux access waited");
    cover property ($rose(mem_sel) && mem_refresh);
    cover property (mp_ready && mp_addr[19:13] == 7'h76);
    cover property ($fell(aux_wait_n));
endmodule
bind sma_arbiter sma_arbiter_monitor #(.MEM_CYC(MEM_CYC))
    sma_arbiter_monitor_inst (.clk(clk), .arst_n(arst_n),
    .aux_address_bus(aux_address_bus), .aux_mem_request_n(aux_mem_request_n),
    .aux_refresh_n(aux_refresh_n), .aux_read_n(aux_read_n),
    .aux_data_bus_oe(aux_data_bus_oe), .aux_wait_n(aux_wait_n),
    .mp_req(mp_req), .mp_addr(mp_addr), .mp_we(mp_we), .mp_rdata(mp_rdata),
    .mp_ready(mp_ready), .ref_req(ref_req), .ref_ack(ref_ack),
    .dma_req(dma_req), .dma_ack(dma_ack), .mem_sel(mem_sel),
    .mem_refresh(mem_refresh), .mem_rdata(mem_rdata));
`default_nettype wire

// *** dv/sma_far_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sma_far_model (
    input  wire logic        clk,
    output logic      [15:0] aux_address_bus,
    output logic      [7:0]  aux_data_bus_in,
    output logic             aux_mem_request_n,
    output logic             aux_port_request_n,
    output logic             aux_opcode_fetch_n,
    output logic             aux_refresh_n,
    output logic             aux_read_n,
    output logic             aux_write_n,
    input  wire logic        aux_wait_n,
    input  wire logic [7:0]  aux_data_bus_out,
    input  wire logic        mem_sel,
    input  wire logic [16:0] mem_addr,
    output logic      [7:0]  mem_rdata
);
    initial begin
        aux_address_bus = 16'hffff; // floated bus shows no address
        aux_data_bus_in = 8'hff;
        aux_mem_request_n = 1'b1; // controls inactive
        aux_port_request_n = 1'b1; // no port exchange modelled
        aux_opcode_fetch_n = 1'b1;
        aux_refresh_n = 1'b1;
        aux_read_n = 1'b1;
        aux_write_n = 1'b1;
        mem_rdata = 8'h00;
    end
    // unselected memory toggles so stale data never looks valid
    always @(posedge clk) begin
        mem_rdata <= mem_sel ? mem_addr[7:0] ^ 8'h3c : ~mem_rdata;
    end
    task automatic access(input logic [15:0] a, input logic f, w, rf,
                          input logic [7:0] d, output int nw,
                          output logic [7:0] q);
        nw = 0;
        @(posedge clk);
        aux_address_bus <= a;
        aux_data_bus_in <= d;
        aux_mem_request_n <= 1'b0;
        aux_opcode_fetch_n <= !f;
        aux_refresh_n <= !rf;
        aux_read_n <= w | rf;
        aux_write_n <= !w | rf;
        for (int i = 0; i < 200; i++) begin
            @(negedge clk);
            if (aux_wait_n === 1'b0) nw++;
            else if (i > 9) break;
        end
        q = aux_data_bus_out;
        @(posedge clk);
        aux_address_bus <= ~a;
        aux_data_bus_in <= ~d;
        aux_mem_request_n <= 1'b1;
        aux_opcode_fetch_n <= 1'b1;
        aux_refresh_n <= 1'b1;
        aux_read_n <= 1'b1;
        aux_write_n <= 1'b1;
        repeat (4) @(posedge clk); // idle bus must outlast the pin filter
    endtask
endmodule
`default_nettype wire

// *** dv/sma_arbiter_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module sma_arbiter_test;
    logic        clk, arst_n, aux_data_bus_oe, aux_mem_request_n, aux_write_n;
    logic        aux_port_request_n, aux_opcode_fetch_n, aux_refresh_n;
    logic        aux_read_n, aux_wait_n, mp_req, mp_we, mp_ready, ref_req;
    logic        ref_ack, dma_req, dma_we, dma_ack, mem_sel, mem_refresh;
    logic        mem_we, nvm_restore_bit_n, nvm_store_bit;
    logic [15:0] aux_address_bus;
    logic [7:0]  aux_data_bus_in, aux_data_bus_out, mp_wdata, mp_rdata;
    logic [7:0]  ext_rdata, dma_wdata, mem_wdata, mem_rdata;
    logic [6:0]  aux_refresh_row;
    logic [19:0] mp_addr;
    logic [16:0] dma_addr, mem_addr;
    int          errors = 0;
    int          checks = 0;
    int          cyc = 0;
    logic [7:0]  wr_seen = 8'h00;
    sma_arbiter #(.STORE_WAIT_CYC(200)) sma_arbiter_inst (.*);
    sma_far_model sma_far_model_inst (.*);
    always @(posedge clk) begin
        if (mem_sel && mem_we) wr_seen <= mem_wdata;
    end
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [19:0] e, g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic mp_go(input logic [19:0] a, input logic w,
                         input logic [7:0] d, output int n,
                         output logic [7:0] r);
        n = 0;
        @(posedge clk);
        mp_addr <= a;
        mp_we <= w;
        mp_wdata <= d;
        mp_req <= 1'b1;
        do begin
            @(negedge clk);
            n++;
        end while (mp_ready !== 1'b1 && n < 200);
        cmp("mp_ready", 20'd1, 20'(mp_ready));
        r = mp_rdata;
        @(posedge clk);
        mp_req <= 1'b0;
    endtask
    task automatic req_go(input logic dma, output int k);
        k = 0;
        @(posedge clk);
        if (dma) dma_req <= 1'b1;
        else ref_req <= 1'b1;
        do begin
            @(negedge clk);
            k++;
        end while ((dma ? dma_ack : ref_ack) !== 1'b1 && k < 200);
        cmp("ack", 20'd1, 20'(dma ? dma_ack : ref_ack));
        @(posedge clk);
        if (dma) dma_req <= 1'b0;
        else ref_req <= 1'b0;
    endtask
    task automatic t_main();
        int n, kr, kd;
        logic [7:0] r;
        mp_go(20'h01234, 1'b1, 8'ha5, n, r);
        cmp("std write wait", 20'd4, 20'(n));
        cmp("std write data", 20'h000a5, 20'(wr_seen));
        mp_go(20'h1f0ff, 1'b0, 8'h00, n, r);
        cmp("std read wait", 20'd4, 20'(n));
        cmp("std read data", 20'h000c3, 20'(r));
        fork
            mp_go(20'h00777, 1'b0, 8'h00, n, r);
            req_go(1'b0, kr);
            req_go(1'b1, kd);
        join
        cmp("refresh before dma", 20'd1, 20'(kr < kd));
        cmp("dma before main", 20'd1, 20'(kd < n));
        cmp("main after ref and dma", 20'd10, 20'(n));
        fork
            req_go(1'b1, kd);
            mp_go(20'h00100, 1'b0, 8'h00, n, r);
        join
        cmp("main after dma", 20'd7, 20'(n));
    endtask
    task automatic t_local();
        int n, k;
        logic [7:0] r;
        mp_go(20'h40010, 1'b0, 8'h00, n, r);
        cmp("local wait", 20'd2, 20'(n));
        cmp("local data", 20'h0009e, 20'(r));
        mp_go(20'hf8000, 1'b0, 8'h00, n, r);
        cmp("rom wait", 20'd2, 20'(n));
        fork
            req_go(1'b0, k);
            begin
                @(posedge clk);
                mp_go(20'hf8000, 1'b0, 8'h00, n, r);
            end
        join
        cmp("rom waits on refresh", 20'd1, 20'(n > 2));
    endtask
    task automatic t_nvm();
        int n;
        logic [7:0] r;
        mp_go(20'hed005, 1'b1, 8'h0a, n, r);
        mp_go(20'hec005, 1'b0, 8'h00, n, r);
        cmp("nvm image read", 20'h0000a, 20'(r));
        @(posedge clk);
        nvm_store_bit <= 1'b1;
        repeat (20) @(posedge clk);
        nvm_store_bit <= 1'b0;
        mp_go(20'hed005, 1'b1, 8'h03, n, r);
        mp_go(20'hed005, 1'b0, 8'h00, n, r);
        cmp("nvm busy read", 20'h00000, 20'(r));
        repeat (220) @(posedge clk);
        mp_go(20'hed005, 1'b0, 8'h00, n, r);
        cmp("nvm write while busy", 20'h0000a, 20'(r));
        mp_go(20'hed005, 1'b1, 8'h06, n, r);
        nvm_restore_bit_n <= 1'b0;
        repeat (90) @(posedge clk);
        nvm_restore_bit_n <= 1'b1;
        mp_go(20'hed005, 1'b0, 8'h00, n, r);
        cmp("nvm restored", 20'h0000a, 20'(r));
    endtask
    task automatic t_aux();
        int nw, np, n;
        logic [7:0] q, r;
        sma_far_model_inst.access(16'h0155, 1'b0, 1'b1, 1'b0, 8'h5a, nw, q);
        sma_far_model_inst.access(16'h0155, 1'b0, 1'b0, 1'b0, 8'h00, nw, q);
        cmp("private wait", 20'd0, 20'(nw));
        cmp("private data", 20'h0005a, 20'(q));
        sma_far_model_inst.access(16'h1234, 1'b0, 1'b0, 1'b0, 8'h00, np, q);
        cmp("shared data", 20'h00008, 20'(q));
        sma_far_model_inst.access(16'h1234, 1'b1, 1'b0, 1'b0, 8'h00, nw, q);
        cmp("fetch extra wait", 20'(np + 1), 20'(nw));
        sma_far_model_inst.access(16'h3f4b, 1'b0, 1'b0, 1'b1, 8'h00, nw, q);
        cmp("refresh row", 20'h0004b, 20'(aux_refresh_row));
        fork
            sma_far_model_inst.access(16'h2000, 1'b0, 1'b0, 1'b0, 8'h00, nw, q);
            begin
                repeat (5) @(posedge clk);
                mp_go(20'h10000, 1'b0, 8'h00, n, r);
            end
        join
        cmp("high bank stalled", 20'd1, 20'(n > 4));
    endtask
    initial begin
        arst_n = 1'b0;
        mp_req = 1'b0;
        mp_addr = 20'h00000;
        mp_we = 1'b0;
        mp_wdata = 8'h00;
        ext_rdata = 8'h9e;
        ref_req = 1'b0;
        dma_req = 1'b0;
        dma_addr = 17'h00200;
        dma_we = 1'b0;
        dma_wdata = 8'h00;
        nvm_restore_bit_n = 1'b1;
        nvm_store_bit = 1'b0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge clk);
        t_main();
        t_local();
        t_nvm();
        t_aux();
        finish_test();
    end
endmodule
`default_nettype wire
